// File: pin_change_detector.sv
// module: per-pin rising/falling edge detector with change flags for three ports
//
// How it works
// - port A pins 0-5 rising edge with rise enable sets change flag
// - port A pins 0-5 falling edge with fall enable sets change flag
// - port B pins 4-7 rising edge with rise enable sets change flag
// - port B pins 4-7 falling edge with fall enable sets change flag
// - port C pins 0-7 rising edge with rise enable sets change flag
// - port C pins 0-7 falling edge with fall enable sets change flag
// - both enables clear means no edge sets the flag; a written one still sets it
// - enabled edge raises both the flag and its interrupt contribution
// - hardware sets flags; software clears by writing zero; reads back zero
// - port A flags in bits 5-0, upper two bits unimplemented
// - port B flags in bits 7-4, lower nibble unimplemented
// - port C flags in eight bits, all zero after reset
// - debugger enabled removes port A pins 0 and 1 detection
// - reset-pin or low-voltage programming enable removes port A pin 3
// - port B registers exist only in the 20-pin variant
// - port C pins 6 and 7 exist only in the 20-pin variant
// - global enable clear still sets flags but raises no interrupt
// - summary flag is the OR of all per-pin flags
// - edge during a clearing write leaves its flag set
// - enabled edge with global enable set wakes from sleep with flags already updated
module pin_change_detector #(
  parameter bit PIN20_VARIANT = 1'b1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] porta_pin,
  input wire logic [7:0] portb_pin,
  input wire logic [7:0] portc_pin,
  input wire logic debug_enable,
  input wire logic reset_pin_enable,
  input wire logic low_voltage_program_enable,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic change_irq,
  output logic change_irq_summary,
  output logic wake_request
);

  // ****************************************
  // implemented-bit masks per port
  // ****************************************
  logic [7:0] impl_mask [3];
  logic [7:0] avail_a_r;
  logic [7:0] avail_a_nxt;

  // port A loses bits to debugger and reset pin; straps move with the system
  always_comb begin
    avail_a_nxt = pin_change_pkg::PORTA_IMPL_MASK;
    if (debug_enable) begin
      avail_a_nxt = avail_a_nxt & ~pin_change_pkg::DEBUG_LOST_MASK;
    end
    if (reset_pin_enable || low_voltage_program_enable) begin
      avail_a_nxt = avail_a_nxt & ~pin_change_pkg::RESET_PIN_LOST_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avail_a_r <= pin_change_pkg::REG_RESET;
    end else begin
      avail_a_r <= avail_a_nxt;
    end
  end

  always_comb begin
    impl_mask[0] = avail_a_r;
    impl_mask[1] = PIN20_VARIANT ? pin_change_pkg::PORTB_IMPL_MASK : 8'h00;
    impl_mask[2] = PIN20_VARIANT ? pin_change_pkg::PORTC_IMPL_MASK_FULL
                                 : pin_change_pkg::PORTC_IMPL_MASK_SMALL;
  end

  // ****************************************
  // address decode
  // ****************************************
  logic [2:0] sel_rise;
  logic [2:0] sel_fall;
  logic [2:0] sel_flags;
  logic sel_ctrl;

  always_comb begin
    sel_rise[0] = reg_addr == pin_change_pkg::PORTA_RISE_ENABLE_OFS;
    sel_fall[0] = reg_addr == pin_change_pkg::PORTA_FALL_ENABLE_OFS;
    sel_flags[0] = reg_addr == pin_change_pkg::PORTA_CHANGE_FLAGS_OFS;
    sel_rise[1] = reg_addr == pin_change_pkg::PORTB_RISE_ENABLE_OFS;
    sel_fall[1] = reg_addr == pin_change_pkg::PORTB_FALL_ENABLE_OFS;
    sel_flags[1] = reg_addr == pin_change_pkg::PORTB_CHANGE_FLAGS_OFS;
    sel_rise[2] = reg_addr == pin_change_pkg::PORTC_RISE_ENABLE_OFS;
    sel_fall[2] = reg_addr == pin_change_pkg::PORTC_FALL_ENABLE_OFS;
    sel_flags[2] = reg_addr == pin_change_pkg::PORTC_CHANGE_FLAGS_OFS;
    sel_ctrl = reg_addr == pin_change_pkg::CHANGE_CTRL_OFS;
  end

  // ****************************************
  // per-port synchroniser, edge detect, enables and flags
  // ****************************************
  logic [7:0] pins [3];
  pin_change_pkg::port_regs_t port_r [3];
  logic [7:0] any_flags [3];

  always_comb begin
    pins[0] = porta_pin;
    pins[1] = portb_pin;
    pins[2] = portc_pin;
  end

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      logic [7:0] sync1_r;
      logic [7:0] sync2_r;
      logic [7:0] prev_r;
      logic [7:0] rise_edge;
      logic [7:0] fall_edge;
      logic [7:0] hit;
      pin_change_pkg::port_regs_t regs_nxt;

      // sync1 feeds only sync2, so a metastable sample never reaches the comparator
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          sync1_r <= pin_change_pkg::REG_RESET;
          sync2_r <= pin_change_pkg::REG_RESET;
          prev_r <= pin_change_pkg::REG_RESET;
        end else begin
          sync1_r <= pins[p];
          sync2_r <= sync1_r;
          prev_r <= sync2_r;
        end
      end

      // pins high out of reset give a spurious rise only if rise enable is set in time
      always_comb begin
        rise_edge = sync2_r & ~prev_r;
        fall_edge = ~sync2_r & prev_r;
        hit = ((rise_edge & port_r[p].rise) | (fall_edge & port_r[p].fall)) & impl_mask[p];
      end

      always_comb begin
        regs_nxt = port_r[p];
        if (reg_wr && sel_rise[p]) begin
          regs_nxt.rise = reg_wdata & impl_mask[p];
        end
        if (reg_wr && sel_fall[p]) begin
          regs_nxt.fall = reg_wdata & impl_mask[p];
        end
        if (reg_wr && sel_flags[p]) begin
          regs_nxt.flags = reg_wdata & impl_mask[p];
        end
        // set wins over a clearing write in the same cycle
        regs_nxt.flags = (regs_nxt.flags | hit) & impl_mask[p];
        regs_nxt.rise = regs_nxt.rise & impl_mask[p];
        regs_nxt.fall = regs_nxt.fall & impl_mask[p];
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          port_r[p] <= '{rise: pin_change_pkg::REG_RESET, fall: pin_change_pkg::REG_RESET,
                         flags: pin_change_pkg::REG_RESET};
        end else begin
          port_r[p] <= regs_nxt;
        end
      end

      always_comb begin
        any_flags[p] = regs_nxt.flags;
      end
    end
  endgenerate

  // ****************************************
  // global enable, summary and interrupt
  // ****************************************
  logic irq_enable_r;
  logic irq_enable_nxt;
  logic summary_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic irq_r;
  logic summary_r;
  logic wake_r;

  always_comb begin
    irq_enable_nxt = irq_enable_r;
    if (reg_wr && sel_ctrl) begin
      irq_enable_nxt = reg_wdata[pin_change_pkg::CTRL_IRQ_ENABLE_BIT];
    end
    summary_nxt = |{any_flags[0], any_flags[1], any_flags[2]};
  end

  always_comb begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < 3; i++) begin
      if (sel_rise[i]) begin
        rdata_nxt = port_r[i].rise;
      end
      if (sel_fall[i]) begin
        rdata_nxt = port_r[i].fall;
      end
      if (sel_flags[i]) begin
        rdata_nxt = port_r[i].flags;
      end
    end
    if (sel_ctrl) begin
      rdata_nxt[pin_change_pkg::CTRL_IRQ_ENABLE_BIT] = irq_enable_r;
      rdata_nxt[pin_change_pkg::CTRL_SUMMARY_BIT] = summary_r;
    end
    if (!reg_rd) begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_enable_r <= 1'b0;
      summary_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      rdata_r <= pin_change_pkg::REG_RESET;
    end else begin
      irq_enable_r <= irq_enable_nxt;
      summary_r <= summary_nxt;
      irq_r <= summary_nxt & irq_enable_nxt;
      wake_r <= summary_nxt & irq_enable_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    reg_rdata = rdata_r;
    change_irq = irq_r;
    change_irq_summary = summary_r;
    wake_request = wake_r;
  end

endmodule : pin_change_detector

// File: pin_change_pkg.sv
// package: register map, field masks and shared types of the pin change detector
package pin_change_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [15:0] PORTA_RISE_ENABLE_OFS = 16'h1F3D;
  localparam logic [15:0] PORTA_FALL_ENABLE_OFS = 16'h1F3E;
  localparam logic [15:0] PORTA_CHANGE_FLAGS_OFS = 16'h1F3F;
  localparam logic [15:0] PORTB_RISE_ENABLE_OFS = 16'h1F48;
  localparam logic [15:0] PORTB_FALL_ENABLE_OFS = 16'h1F49;
  localparam logic [15:0] PORTB_CHANGE_FLAGS_OFS = 16'h1F4A;
  localparam logic [15:0] PORTC_RISE_ENABLE_OFS = 16'h1F53;
  localparam logic [15:0] PORTC_FALL_ENABLE_OFS = 16'h1F54;
  localparam logic [15:0] PORTC_CHANGE_FLAGS_OFS = 16'h1F55;
  localparam logic [15:0] CHANGE_CTRL_OFS = 16'h1F56;

  // ****************************************
  // implemented bits and reset values
  // ****************************************
  localparam logic [7:0] PORTA_IMPL_MASK = 8'h3F;
  localparam logic [7:0] PORTB_IMPL_MASK = 8'hF0;
  localparam logic [7:0] PORTC_IMPL_MASK_FULL = 8'hFF;
  localparam logic [7:0] PORTC_IMPL_MASK_SMALL = 8'h3F;
  localparam logic [7:0] DEBUG_LOST_MASK = 8'h03;
  localparam logic [7:0] RESET_PIN_LOST_MASK = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CTRL_IRQ_ENABLE_BIT = 0;
  localparam int CTRL_SUMMARY_BIT = 1;

  // ****************************************
  // shared types
  // ****************************************
  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flags;
  } port_regs_t;

endpackage : pin_change_pkg

// File: pin_change_props.sv
// checker: port-level properties of the pin change detector
module pin_change_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] porta_pin,
  input wire logic [7:0] portb_pin,
  input wire logic [7:0] portc_pin,
  input wire logic debug_enable,
  input wire logic reset_pin_enable,
  input wire logic low_voltage_program_enable,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic change_irq,
  input wire logic change_irq_summary,
  input wire logic wake_request
);
  // ****
  // properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic lost = debug_enable | reset_pin_enable | low_voltage_program_enable;
  wire logic [23:0] pins = {porta_pin, portb_pin, portc_pin};
  a_irq_needs_flag: assert property (change_irq |-> change_irq_summary)
    else $error("irq without any flag");
  a_wake_follows_irq: assert property (wake_request == change_irq)
    else $error("wake differs from irq");
  a_porta_upper_zero: assert property ($past(reg_rd && reg_addr == 16'h1F3F) |-> reg_rdata[7:6] == 2'b00)
    else $error("port a upper flag bits set");
  a_portb_lower_zero: assert property ($past(reg_rd && reg_addr == 16'h1F4A) |-> reg_rdata[3:0] == 4'h0)
    else $error("port b lower flag bits set");
  a_unmapped_reads_zero: assert property (reg_rd && reg_addr == 16'h1F40 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  // a flag comes 3 edges after the pin sample changed, or from a write
  a_rise_has_cause: assert property ($rose(change_irq_summary) |-> $past(pins, 3) != $past(pins, 4) || $past(reg_wr))
    else $error("summary rose without cause");
  a_fall_has_cause: assert property ($fell(change_irq_summary) |-> $past(reg_wr) || $past(lost) || $past(lost, 2))
    else $error("summary fell without clear");
  cover property ($rose(change_irq));
  cover property ($rose(change_irq_summary) && !change_irq);
  cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : pin_change_props

bind pin_change_detector pin_change_props i_props (.*);

// File: pin_drive_model.sv
// model: external source driving the three port pin groups
module pin_drive_model (
  input wire logic mclk,
  output logic [7:0] porta_pin,
  output logic [7:0] portb_pin,
  output logic [7:0] portc_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {porta_pin, portb_pin, portc_pin} = 24'h000000;
  // push-pull source, so pins never float; slow delays by whole cycles
  task drive(input logic [23:0] v, input int slow);
    repeat (slow) @(posedge mclk);
    @(posedge mclk);
    {porta_pin, portb_pin, portc_pin} <= v;
  endtask : drive
endmodule : pin_drive_model

// File: tb_pin_change_detector.sv
// testbench: register and pin edge scenarios of the pin change detector
module tb_pin_change_detector;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rstn, debug_enable, reset_pin_enable, low_voltage_program_enable, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, porta_pin, portb_pin, portc_pin;
  logic change_irq, change_irq_summary, wake_request;
  logic [7:0] small_rdata;
  int mismatches, n_compared;
  logic [15:0] bases [3] = '{16'h1F3D, 16'h1F48, 16'h1F53};
  logic [7:0] masks [3] = '{8'h3F, 8'hF0, 8'hFF};
  pin_change_detector i_dut (.*);
  // small variant shares the bus and pins; only its read data is judged
  pin_change_detector #(.PIN20_VARIANT(1'b0)) i_dut_small (
    .mclk(mclk),
    .rstn(rstn),
    .porta_pin(porta_pin),
    .portb_pin(portb_pin),
    .portc_pin(portc_pin),
    .debug_enable(debug_enable),
    .reset_pin_enable(reset_pin_enable),
    .low_voltage_program_enable(low_voltage_program_enable),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(small_rdata),
    .change_irq(),
    .change_irq_summary(),
    .wake_request()
  );
  pin_drive_model i_pins (.*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ****
  // bus tasks
  // ****
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // ****
  // scenarios
  // ****
  task reset_values;
    for (int i = 0; i < 9; i++) rd(bases[i / 3] + 16'(i % 3), 8'h00);
    rd(16'h1F40, 8'h00);
  endtask : reset_values
  task edge_case(input int p, input bit rise);
    logic [23:0] lvl;
    lvl = 24'hFF0000 >> (8 * p);
    wr(bases[p], rise ? 8'hFF : 8'h00);
    wr(bases[p] + 16'h1, rise ? 8'h00 : 8'hFF);
    rd(bases[p], rise ? masks[p] : 8'h00);
    i_pins.drive(rise ? 24'h0 : lvl, 0);
    repeat (4) @(posedge mclk);
    wr(bases[p] + 16'h2, 8'h00);
    i_pins.drive(rise ? lvl : 24'h0, 1);
    repeat (5) @(posedge mclk);
    rd(bases[p] + 16'h2, masks[p]);
    chk({6'h00, change_irq_summary, change_irq}, 8'h02);
    wr(16'h1F56, 8'h01);
    @(posedge mclk);
    #1 chk({6'h00, change_irq, wake_request}, 8'h03);
    rd(16'h1F56, 8'h03);
    wr(16'h1F56, 8'h00);
    wr(bases[p] + 16'h2, 8'h00);
    rd(bases[p] + 16'h2, 8'h00);
  endtask : edge_case
  task no_enable;
    // port C fall enable is still set by the last edge scenario
    wr(16'h1F54, 8'h00);
    i_pins.drive(24'h0000FF, 0);
    i_pins.drive(24'h000000, 5);
    repeat (5) @(posedge mclk);
    rd(16'h1F55, 8'h00);
  endtask : no_enable
  task lost_pins;
    @(posedge mclk);
    debug_enable <= 1'b1;
    reset_pin_enable <= 1'b1;
    wr(16'h1F3D, 8'hFF);
    rd(16'h1F3D, 8'h34);
    i_pins.drive(24'hFF0000, 0);
    repeat (5) @(posedge mclk);
    rd(16'h1F3F, 8'h34);
    wr(16'h1F3D, 8'h00);
    wr(16'h1F3E, 8'h00);
    debug_enable <= 1'b0;
    reset_pin_enable <= 1'b0;
    low_voltage_program_enable <= 1'b1;
    wr(16'h1F3F, 8'h00);
    wr(16'h1F3D, 8'hFF);
    rd(16'h1F3D, 8'h37);
    wr(16'h1F3D, 8'h00);
    low_voltage_program_enable <= 1'b0;
  endtask : lost_pins
  task small_variant;
    wr(16'h1F54, 8'hFF);
    rd(16'h1F54, 8'hFF);
    chk(small_rdata, 8'h3F);
    wr(16'h1F48, 8'hFF);
    rd(16'h1F48, 8'hF0);
    chk(small_rdata, 8'h00);
    wr(16'h1F54, 8'h00);
    wr(16'h1F48, 8'h00);
  endtask : small_variant
  task clear_race;
    wr(16'h1F53, 8'hFF);
    i_pins.drive(24'h0000FF, 0);
    @(posedge mclk);
    wr(16'h1F55, 8'h00);
    rd(16'h1F55, 8'hFF);
  endtask : clear_race
  initial begin
    {rstn, reg_wr, reg_rd, debug_enable, reset_pin_enable, low_voltage_program_enable} = 6'h00;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    reset_values;
    for (int p = 0; p < 3; p++) begin
      edge_case(p, 1'b1);
      edge_case(p, 1'b0);
    end
    no_enable;
    lost_pins;
    small_variant;
    clear_race;
    end_sim;
  end
  // guard against a hang: about 50000 cycles
  initial begin
    #2000000;
    mismatches++;
    end_sim;
  end
endmodule : tb_pin_change_detector
